// File: hw/serial_audio_cfg.svh
`ifndef SERIAL_AUDIO_CFG_SVH
`define SERIAL_AUDIO_CFG_SVH

// Preamble codes in the low four descriptor bits
`define CFG_CODE_B      4'h0
`define CFG_CODE_M      4'h1
`define CFG_CODE_W      4'h2
// Preamble half-cell patterns, first half in bit 7, for a prior level of 0
`define CFG_PRE_B       8'hE8
`define CFG_PRE_M       8'hE2
`define CFG_PRE_W       8'hE4
// Half-cell and slot positions in one word
`define CFG_IEC_LAST    6'h3F
`define CFG_RAW_LAST    6'h1F
`define CFG_PRE_HALVES  6'h08
`define CFG_PARITY_SLOT 5'h1F
// Fetch stepping
`define CFG_WORD_BYTES  32'h0000_0004
// Synthesizer: rate is (setting - 2^31) * 9 * f_clk / 2^32
`define CFG_DDS_OFFSET  32'h8000_0000
`define CFG_DDS_MULT    36'h0_0000_0009
// Reset values
`define CFG_RST_WORD    32'h0000_0000
`define CFG_RST_POS     6'h00

`endif

// File: hw/serial_audio_pkg.sv
package serial_audio_pkg;

	typedef enum logic [1:0] {
		SER_IDLE = 2'b01,
		SER_RUN  = 2'b10
	} ser_state_t;

	typedef struct packed {
		logic [31:0] acc;
		logic        tick;
	} dds_state_t;

	typedef struct packed {
		ser_state_t  st;
		logic        line;
		logic        pre_lvl;
		logic [5:0]  pos;
		logic [31:0] sh;
		logic        cur_first;
		logic        cur_last;
		logic        held_v;
		logic [31:0] held;
		logic        held_first;
		logic        held_last;
		logic        req;
		logic [31:0] addr;
		logic        fetch_second;
		logic [31:0] foff;
		logic        drained1;
		logic        drained2;
		logic        starve;
		logic        underrun;
		logic        irq;
		logic [31:0] tcnt;
		logic [31:0] ts;
	} tx_state_t;

endpackage : serial_audio_pkg

// File: hw/direct_digital_synth.sv
`timescale 1ns/100ps
`include "serial_audio_cfg.svh"

module direct_digital_synth
	import serial_audio_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic [31:0] freq,
	output logic             tick
);
	dds_state_t  s;
	dds_state_t  next_s;
	logic [35:0] step;
	logic [35:0] sum;

	// Settings below the offset mean a stopped clock
	always_comb begin
		step = (freq >= `CFG_DDS_OFFSET) ? ({4'h0, freq - `CFG_DDS_OFFSET} * `CFG_DDS_MULT) : 36'h0_0000_0000;
		sum = {4'h0, s.acc} + step;
		next_s = s;
		// Only the phase rate changes on a new setting, never the level
		next_s.acc = sum[31:0]; // R14
		// One tick per synthesized period; rates above the core clock saturate
		next_s.tick = |sum[35:32]; // R13
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign tick = s.tick;

endmodule : direct_digital_synth

// File: hw/serial_audio_tx.sv
`timescale 1ns/100ps
`include "serial_audio_cfg.svh"

// Functional notes
// [R1] Bi-phase mark: invert at cell start, ones mid-cell
// [R2] Each half-cell lasts one synthesized clock
// [R3] Preambles violate coding and start rising
// [R4] Parity makes cells 4..31 even ones
// [R5] Software keeps descriptor bit 31 zero
// [R6] Payload bits copied unchanged to slots
// [R7] Low nibble 0/1/2 selects B/M/W preamble
// [R8] Software writes 384 descriptors per block
// [R9] Software sizes buffers in 64-byte multiples
// [R10] Little-endian: byte a+3 most significant
// [R11] Big-endian: byte a most significant
// [R12] Sub-frame is 64 UI, frame 128
// [R13] Bit clock from phase accumulator times nine
// [R14] Frequency change alters rate, not level
// [R15] Raw mode shifts 32 bits, selectable order
// [R16] Raw mode: one bit per synthesized clock
// [R17] Software sets bases and size before enable
// [R18] Enable starts buffer one, alternates buffers
// [R19] Drain: timestamp, flag, active bit, switch
// [R20] Refill acknowledge clears drained flag
// [R21] Both drained: sticky underrun, keep switching
// [R22] Prefetch empty at load sets starvation flag
// [R23] Interrupt when any enabled flag set
// [R24] Acknowledge clears flag the next cycle
// [R25] Active bit high while buffer one emits
// [R26] Preamble, slots 4..30 LSB first, parity
module serial_audio_tx
	import serial_audio_pkg::*;
(
	input  wire logic        CORE_CLK,
	input  wire logic        RST_N,
	input  wire logic        TRANSMIT_ENABLE,
	input  wire logic        RAW_MODE,
	input  wire logic        RAW_BIT_ORDER_SELECT,
	input  wire logic        LITTLE_ENDIAN,
	input  wire logic [31:0] FREQUENCY,
	input  wire logic [31:0] FIRST_BUFFER_BASE,
	input  wire logic [31:0] SECOND_BUFFER_BASE,
	input  wire logic [31:0] BUFFER_BYTE_COUNT,
	input  wire logic        FIRST_BUFFER_REFILL_ACK,
	input  wire logic        SECOND_BUFFER_REFILL_ACK,
	input  wire logic        UNDERRUN_CLEAR,
	input  wire logic        STARVATION_CLEAR,
	input  wire logic        FIRST_DRAINED_IRQ_ENABLE,
	input  wire logic        SECOND_DRAINED_IRQ_ENABLE,
	input  wire logic        UNDERRUN_IRQ_ENABLE,
	input  wire logic        STARVATION_IRQ_ENABLE,
	output logic             MEM_REQ,
	output logic [31:0]      MEM_ADDR,
	input  wire logic        MEM_ACK,
	input  wire logic [31:0] MEM_RDATA,
	output logic             SERIAL_AUDIO_OUTPUT,
	output logic             FIRST_BUFFER_IN_USE,
	output logic             FIRST_BUFFER_DRAINED,
	output logic             SECOND_BUFFER_DRAINED,
	output logic             UNDERRUN,
	output logic             FETCH_STARVATION_ERROR,
	output logic             IRQ,
	output logic [31:0]      TIMESTAMP
);
	tx_state_t s;
	tx_state_t next_s;
	logic      tick;
	logic      load;
	logic      wrap;
	logic      drain1;
	logic      drain2;
	logic      starve_ev;
	logic      data_bit;
	logic      lvl;
	logic [4:0] slot;
	logic [7:0] pat;

	// Byte lanes of MEM_RDATA: byte a in [7:0] up to byte a+3 in [31:24]
	function automatic logic [31:0] assemble(input logic [31:0] raw, input logic little);
		logic [31:0] w;
		w = raw; // R10
		if (!little) begin
			for (int i = 0; i < 4; i++) begin
				w[8*i +: 8] = raw[8*(3-i) +: 8]; // R11
			end
		end
		return w;
	endfunction : assemble

	// Reserved codes fall back to the B pattern
	function automatic logic [7:0] preamble(input logic [3:0] code);
		logic [7:0] p;
		case (code) // R7
			`CFG_CODE_M: p = `CFG_PRE_M;
			`CFG_CODE_W: p = `CFG_PRE_W;
			default:     p = `CFG_PRE_B;
		endcase
		return p;
	endfunction : preamble

	direct_digital_synth u_dds (
		.clk   (CORE_CLK),
		.rst_n (RST_N),
		.freq  (FREQUENCY),
		.tick  (tick)
	);

	// Event decode for the current state
	always_comb begin
		wrap = (s.st == SER_RUN) && tick && (s.pos == (RAW_MODE ? `CFG_RAW_LAST : `CFG_IEC_LAST));
		load = TRANSMIT_ENABLE && (((s.st == SER_IDLE) && s.held_v) || wrap);
		drain1 = wrap && s.cur_last && s.cur_first; // R19
		drain2 = wrap && s.cur_last && !s.cur_first; // R19
		starve_ev = wrap && TRANSMIT_ENABLE && !s.held_v; // R22
		slot = s.pos[5:1];
		// Parity over slots 4..30 keeps the sub-frame count even
		data_bit = (slot == `CFG_PARITY_SLOT) ? ^s.sh[30:4] : s.sh[slot]; // R4 R6
		lvl = (s.pos == `CFG_RST_POS) ? s.line : s.pre_lvl;
		pat = preamble(s.sh[3:0]);
	end

	// Next state: fetch, serializer and sticky flags
	always_comb begin
		next_s = s;
		next_s.tcnt = s.tcnt + 32'h0000_0001;
		if (!TRANSMIT_ENABLE) begin
			// Disable restarts from buffer one on the next enable
			next_s.st = SER_IDLE;
			next_s.req = 1'b0;
			next_s.held_v = 1'b0;
			next_s.fetch_second = 1'b0;
			next_s.foff = `CFG_RST_WORD;
		end else begin
			// One-word prefetch store; a new fetch goes out once it is free
			if (!s.req && !s.held_v) begin
				next_s.req = 1'b1;
				next_s.addr = (s.fetch_second ? SECOND_BUFFER_BASE : FIRST_BUFFER_BASE) + s.foff; // R18
			end
			if (s.req && MEM_ACK) begin
				next_s.req = 1'b0;
				next_s.held_v = 1'b1;
				next_s.held = assemble(MEM_RDATA, LITTLE_ENDIAN);
				next_s.held_first = !s.fetch_second;
				next_s.held_last = (s.foff + `CFG_WORD_BYTES >= BUFFER_BYTE_COUNT);
				if (s.foff + `CFG_WORD_BYTES >= BUFFER_BYTE_COUNT) begin
					// Alternate buffers whether or not software refilled them
					next_s.fetch_second = !s.fetch_second; // R18 R21
					next_s.foff = `CFG_RST_WORD;
				end else begin
					next_s.foff = s.foff + `CFG_WORD_BYTES;
				end
			end
			// Half-cell emission, one per synthesized tick
			if ((s.st == SER_RUN) && tick) begin // R2
				next_s.pos = wrap ? `CFG_RST_POS : s.pos + 6'h01; // R12
				if (RAW_MODE) begin
					next_s.line = RAW_BIT_ORDER_SELECT ? s.sh[5'h1F - s.pos[4:0]] : s.sh[s.pos[4:0]]; // R15 R16
				end else if (s.pos < `CFG_PRE_HALVES) begin
					// Pattern is relative to the level left by the previous parity
					next_s.pre_lvl = lvl;
					next_s.line = pat[3'h7 - s.pos[2:0]] ^ lvl; // R3 R26
				end else if (!s.pos[0]) begin
					next_s.line = !s.line; // R1
				end else begin
					next_s.line = s.line ^ data_bit; // R1 R26
				end
			end
			if (load) begin
				next_s.st = SER_RUN;
				next_s.pos = `CFG_RST_POS;
				if (s.held_v) begin
					next_s.held_v = 1'b0;
					next_s.sh = s.held;
					next_s.cur_first = s.held_first; // R25
					next_s.cur_last = s.held_last;
				end else begin
					// Starved: repeat the previous word, and do not drain twice
					next_s.cur_last = 1'b0;
				end
			end
		end
		if (drain1 || drain2) begin
			next_s.ts = s.tcnt; // R19
		end
		// Hardware set wins over a same-cycle acknowledge
		next_s.drained1 = (s.drained1 && !FIRST_BUFFER_REFILL_ACK) || drain1; // R20 R24
		next_s.drained2 = (s.drained2 && !SECOND_BUFFER_REFILL_ACK) || drain2; // R20 R24
		next_s.underrun = (s.underrun && !UNDERRUN_CLEAR) || (drain1 && s.drained2) || (drain2 && s.drained1); // R21 R24
		next_s.starve = (s.starve && !STARVATION_CLEAR) || starve_ev; // R22 R24
		next_s.irq = (next_s.drained1 && FIRST_DRAINED_IRQ_ENABLE) || (next_s.drained2 && SECOND_DRAINED_IRQ_ENABLE)
			|| (next_s.underrun && UNDERRUN_IRQ_ENABLE) || (next_s.starve && STARVATION_IRQ_ENABLE); // R23
	end

	// Single register stage for all state
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			s <= '0;
			s.st <= SER_IDLE;
			s.cur_first <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// Outputs are taken straight from the state register
	assign MEM_REQ = s.req;
	assign MEM_ADDR = s.addr;
	assign SERIAL_AUDIO_OUTPUT = s.line;
	assign FIRST_BUFFER_IN_USE = s.cur_first;
	assign FIRST_BUFFER_DRAINED = s.drained1;
	assign SECOND_BUFFER_DRAINED = s.drained2;
	assign UNDERRUN = s.underrun;
	assign FETCH_STARVATION_ERROR = s.starve;
	assign IRQ = s.irq;
	assign TIMESTAMP = s.ts;

	// Checks
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RST_N);

	a_line_hold: assert property (!tick |=> $stable(SERIAL_AUDIO_OUTPUT)) // R2
		else $error("line changed without a synthesized tick");
	a_cell_invert: assert property (tick && s.st == SER_RUN && !RAW_MODE && s.pos >= `CFG_PRE_HALVES && !s.pos[0]
		&& TRANSMIT_ENABLE |=> SERIAL_AUDIO_OUTPUT != $past(SERIAL_AUDIO_OUTPUT)) // R1
		else $error("cell start did not invert");
	a_parity_even: assert property (tick && s.st == SER_RUN && !RAW_MODE && s.pos == `CFG_IEC_LAST && TRANSMIT_ENABLE
		|=> SERIAL_AUDIO_OUTPUT == s.pre_lvl) // R4
		else $error("sub-frame ended on wrong level");
	a_preamble_rise: assert property (tick && s.st == SER_RUN && !RAW_MODE && s.pos == `CFG_RST_POS
		&& TRANSMIT_ENABLE && !SERIAL_AUDIO_OUTPUT |=> SERIAL_AUDIO_OUTPUT) // R3
		else $error("preamble did not start rising");
	a_raw_order: assert property (tick && s.st == SER_RUN && RAW_MODE && !RAW_BIT_ORDER_SELECT && TRANSMIT_ENABLE
		|=> SERIAL_AUDIO_OUTPUT == $past(s.sh[s.pos[4:0]])) // R15
		else $error("raw bit out of order");
	a_big_endian: assert property (s.req && MEM_ACK && TRANSMIT_ENABLE && !LITTLE_ENDIAN
		|=> s.held[31:24] == $past(MEM_RDATA[7:0]) && s.held[7:0] == $past(MEM_RDATA[31:24])) // R11
		else $error("byte order wrong");
	a_drain_flag: assert property (drain1 |=> FIRST_BUFFER_DRAINED && TIMESTAMP == $past(s.tcnt)) // R19
		else $error("drain not flagged");
	a_ack_clear: assert property (FIRST_BUFFER_DRAINED && FIRST_BUFFER_REFILL_ACK && !drain1 |=> !FIRST_BUFFER_DRAINED) // R20
		else $error("acknowledge did not clear");
	// Either buffer may be the second to drain; the bench reaches the second case
	a_underrun_set: assert property ((drain2 && FIRST_BUFFER_DRAINED) || (drain1 && SECOND_BUFFER_DRAINED)
		|=> UNDERRUN [*2]) // R21
		else $error("underrun not raised");
	a_starve_set: assert property (starve_ev |=> FETCH_STARVATION_ERROR) // R22
		else $error("starvation not flagged");
	a_irq_gate: assert property (UNDERRUN && UNDERRUN_IRQ_ENABLE |-> IRQ) // R23
		else $error("interrupt missing");

	c_drain_both: cover property (drain1 ##[1:1000] drain2);
	c_underrun: cover property ($rose(UNDERRUN));
	c_starve: cover property ($rose(FETCH_STARVATION_ERROR));
	c_raw_msb: cover property (tick && RAW_MODE && RAW_BIT_ORDER_SELECT && s.st == SER_RUN);

endmodule : serial_audio_tx

// File: tb/sample_memory.sv
`timescale 1ns/100ps

// Word memory behind the fetch port, with an adjustable answer delay
module sample_memory (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        req,
	input  wire logic [31:0] addr,
	output logic             ack,
	output logic [31:0]      rdata
);
	logic [31:0] words [0:31];
	int          latency = 2;
	int          waited;

	// One answer per request; the data bus churns whenever no word is presented
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ack <= 1'h0;
			rdata <= 32'h0000_0000;
			waited <= 0;
		end else if (req && !ack && waited >= latency) begin
			ack <= 1'h1;
			rdata <= words[addr[6:2]];
			waited <= 0;
		end else begin
			ack <= 1'h0;
			rdata <= ~rdata;
			waited <= (req && !ack) ? waited + 1 : 0;
		end
	end
endmodule : sample_memory

// File: tb/serial_audio_tx_test.sv
`timescale 1ns/100ps

module serial_audio_tx_test;
	import serial_audio_pkg::*;
	logic        clk = 1'h0;
	logic        rst_n = 1'h0;
	logic        en = 1'h0;
	logic        raw = 1'h0;
	logic        order = 1'h0;
	logic        le = 1'h1;
	logic        lvl = 1'h0;
	logic [3:0]  pulse = 4'h0;
	logic [3:0]  irq_en = 4'h0;
	logic [31:0] freq = 32'h838E_38E4;
	logic        mreq, mack, sout, in_use, drn1, drn2, udr, starve, irq;
	logic [31:0] maddr, mdata, tstamp;
	bit          exp_q[$];
	int          mismatches = 0;
	int          comparisons = 0;
	wire logic [5:0] status = {in_use, drn1, drn2, udr, starve, irq};

	// 250 MHz core clock
	initial begin
		forever #2 clk = ~clk;
	end

	// Rate setting gives exactly eight core cycles per half-cell for a long stretch
	serial_audio_tx dut_u (
		.CORE_CLK(clk), .RST_N(rst_n), .TRANSMIT_ENABLE(en), .RAW_MODE(raw), .RAW_BIT_ORDER_SELECT(order),
		.LITTLE_ENDIAN(le), .FREQUENCY(freq), .FIRST_BUFFER_BASE(32'h0000_0000),
		.SECOND_BUFFER_BASE(32'h0000_0040), .BUFFER_BYTE_COUNT(32'h0000_0040),
		.FIRST_BUFFER_REFILL_ACK(pulse[0]), .SECOND_BUFFER_REFILL_ACK(pulse[1]), .UNDERRUN_CLEAR(pulse[2]),
		.STARVATION_CLEAR(pulse[3]), .FIRST_DRAINED_IRQ_ENABLE(irq_en[0]), .SECOND_DRAINED_IRQ_ENABLE(irq_en[1]),
		.UNDERRUN_IRQ_ENABLE(irq_en[2]), .STARVATION_IRQ_ENABLE(irq_en[3]), .MEM_REQ(mreq), .MEM_ADDR(maddr),
		.MEM_ACK(mack), .MEM_RDATA(mdata), .SERIAL_AUDIO_OUTPUT(sout), .FIRST_BUFFER_IN_USE(in_use),
		.FIRST_BUFFER_DRAINED(drn1), .SECOND_BUFFER_DRAINED(drn2), .UNDERRUN(udr),
		.FETCH_STARVATION_ERROR(starve), .IRQ(irq), .TIMESTAMP(tstamp)
	);
	sample_memory mem_u (.clk(clk), .rst_n(rst_n), .req(mreq), .addr(maddr), .ack(mack), .rdata(mdata));

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask : check

	task automatic give_verdict();
		$display("comparisons %0d, mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : give_verdict

	// Expected half-cells of one word, built from the memory image
	task automatic push(input int idx);
		logic [31:0] w;
		logic [7:0]  pre;
		w = mem_u.words[idx % 32];
		if (!le) w = {w[7:0], w[15:8], w[23:16], w[31:24]};
		if (raw) begin
			for (int i = 0; i < 32; i++) exp_q.push_back(order ? w[31 - i] : w[i]);
		end else begin
			case (w[3:0])
				4'h1: pre = 8'hE2;
				4'h2: pre = 8'hE4;
				default: pre = 8'hE8;
			endcase
			for (int i = 7; i >= 0; i--) exp_q.push_back(pre[i] ^ lvl);
			lvl = lvl ^ pre[0];
			w[31] = ^w[30:4];
			for (int s = 4; s < 32; s++) begin
				lvl = ~lvl;
				exp_q.push_back(lvl);
				lvl = lvl ^ w[s];
				exp_q.push_back(lvl);
			end
		end
	endtask : push

	// One half-cell: any pulse stands for its first cycle, the line is sampled mid-cell
	task automatic step(input logic [3:0] p, input int edges = 8);
		for (int k = 0; k < edges; k++) begin
			@(posedge clk);
			pulse <= (k == 0) ? p : 4'h0;
		end
		#1;
		check("serial line", sout, exp_q.pop_front());
	endtask : step

	task automatic run(input int first, input int n);
		for (int k = first; k < first + n; k++) begin
			push(k);
			repeat (raw ? 32 : 64) step(4'h0);
		end
	endtask : run

	task automatic do_reset(input logic r, input logic o, input logic l, input logic [3:0] ie);
		@(posedge clk);
		en <= 1'h0;
		rst_n <= 1'h0;
		raw <= r;
		order <= o;
		le <= l;
		irq_en <= ie;
		repeat (2) @(posedge clk);
		rst_n <= 1'h1;
		lvl = 1'h0;
		exp_q.delete();
	endtask : do_reset

	// Enable, then lock onto the first rising edge of the stream
	task automatic start();
		int n;
		n = 0;
		@(posedge clk);
		en <= 1'h1;
		while (sout !== 1'h1 && n < 3000) begin
			@(posedge clk);
			#1;
			n++;
		end
		check("stream start", sout, 1'h1);
		push(0);
		step(4'h0, 4);
		repeat ((raw ? 32 : 64) - 1) step(4'h0);
	endtask : start

	// Sub-frames over three buffer turns, then both raw orders, then a slow memory
	initial begin
		logic [31:0] d;
		int          n;
		d = $urandom(49);
		for (int i = 0; i < 32; i++) begin
			d = $urandom();
			d[31] = 1'h0;
			d[3:0] = (i == 0) ? 4'h0 : (i == 6) ? 4'h3 : (i % 2) ? 4'h2 : 4'h1;
			mem_u.words[i] = d;
		end
		do_reset(1'h0, 1'h0, 1'h1, 4'h5);
		#1;
		check("status", status, 6'h20);
		start();
		run(1, 15);
		push(16);
		step(4'h0);
		check("status", status, 6'h11);
		d = tstamp;
		step(4'h1);
		check("status", status, 6'h00);
		repeat (62) step(4'h0);
		run(17, 15);
		push(32);
		step(4'h0);
		check("status", status, 6'h28);
		check("timestamp", tstamp - d, 32'h0000_2000);
		d = tstamp;
		repeat (63) step(4'h0);
		run(33, 15);
		push(48);
		step(4'h0);
		check("status", status, 6'h1D);
		check("timestamp", tstamp - d, 32'h0000_2000);
		step(4'h1);
		check("status", status, 6'h0D);
		step(4'h4);
		check("status", status, 6'h08);
		repeat (61) step(4'h0);
		mem_u.words[0] = 32'h8100_0081;
		for (int o = 0; o < 2; o++) begin
			do_reset(1'h1, o[0], 1'h0, 4'h8);
			start();
			run(1, 19);
		end
		mem_u.latency = 400;
		n = 0;
		while (starve !== 1'h1 && n < 3000) begin
			@(posedge clk);
			n++;
		end
		#1;
		check("starvation", {starve, irq}, 2'h3);
		mem_u.latency = 2;
		repeat (1000) @(posedge clk);
		pulse <= 4'h8;
		@(posedge clk);
		pulse <= 4'h0;
		#1;
		check("starvation", {starve, irq}, 2'h0);
		// Stopping the synthesizer must freeze the line at its present level
		@(posedge clk);
		freq <= 32'h8000_0000;
		repeat (2) @(posedge clk);
		#1;
		d = {31'h0, sout};
		repeat (100) @(posedge clk);
		#1;
		check("line after rate change", sout, d[0]);
		give_verdict();
	end

	// Watchdog: the run needs about 37000 cycles, so 100000 means a hang
	initial begin
		#400000;
		mismatches++;
		give_verdict();
	end
endmodule : serial_audio_tx_test
